// File: pkg/lsd_pkg.sv
// Shared constants and types for the LCD segment and common drive block
package lsd_pkg;

   // ---------------------------------------------------------------
   // Panel geometry
   // ---------------------------------------------------------------
   localparam int SEGS_LARGE    = 32;
   localparam int SEGS_SMALL    = 24;
   localparam int NUM_COMS      = 4;
   localparam int KEY_SEG_FIRST = 16;
   localparam int KEY_SEG_NUM   = 8;
   localparam int NIB_SEG_NUM   = 4;

   // ---------------------------------------------------------------
   // Display memory indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [15:0] DMEM_FIRST_IDX      = 16'hFA40;
   localparam logic [15:0] DMEM_LAST_LARGE_IDX = 16'hFA5F;
   localparam logic [15:0] DMEM_LAST_SMALL_IDX = 16'hFA57;
   localparam logic [15:0] DMEM_NIB_LAST_IDX   = 16'hFA43;
   localparam logic [31:0] DMEM_BASE_ADDR      = {14'h0000, DMEM_FIRST_IDX, 2'b00};

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   localparam logic [31:0] CTRL_ADDR   = 32'h0000_0000;
   localparam logic [31:0] PAT_A_ADDR  = 32'h0000_0004;
   localparam logic [31:0] PAT_B_ADDR  = 32'h0000_0008;
   localparam logic [31:0] STAT_ADDR   = 32'h0000_000C;
   localparam int          CTRL_ON_BIT = 0;
   localparam int          CTRL_KS_BIT = 1;
   localparam int          CTRL_SL_LSB = 4;
   localparam int          CTRL_BI_LSB = 8;
   localparam logic [7:0]  PAT_RESET   = 8'h00;
   localparam int          STAT_PH_LSB  = 0;
   localparam int          STAT_COM_LSB = 4;
   localparam int          STAT_POL_BIT = 8;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int HCLK_PERIOD_NS     = 5;
   localparam int LCD_HALF_PERIOD_NS = 500000;
   localparam int LCD_HALF_CYCLES    = LCD_HALF_PERIOD_NS / HCLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      LVL_GND  = 3'h0,
      LVL_MID1 = 3'h1,
      LVL_MID2 = 3'h2,
      LVL_MID3 = 3'h3,
      LVL_TOP  = 3'h4,
      LVL_VDD  = 3'h5
   } lsd_lvl_e;

   typedef enum logic [1:0] {
      SL_STATIC = 2'h0,
      SL_TWO    = 2'h1,
      SL_THREE  = 2'h2,
      SL_FOUR   = 2'h3
   } lsd_slice_e;

   typedef enum logic [1:0] {
      BI_STATIC  = 2'h0,
      BI_HALF    = 2'h1,
      BI_THIRD   = 2'h2,
      BI_QUARTER = 2'h3
   } lsd_bias_e;

   typedef enum logic [1:0] {
      PH_DISP   = 2'b00,
      PH_KEY_LO = 2'b01,
      PH_KEY_HI = 2'b11
   } lsd_phase_e;

endpackage

// File: hdl/lsd_level_enc.sv
// Drive level select encoder for one common or segment line
`timescale 1ns/10ps
module lsd_level_enc
   import lsd_pkg::*;
(
   input  wire logic      is_com,
   input  wire logic      sel,
   input  wire logic      pol,
   input  wire logic      key,
   input  wire logic      kbit,
   input  wire lsd_bias_e bias,
   output lsd_lvl_e       level
);

   // ---------------------------------------------------------------
   // Level per bias, line kind and polarity
   // ---------------------------------------------------------------
   always_comb begin
      level = LVL_GND;
      if (key) begin
         level = kbit ? LVL_VDD : LVL_GND;
      end else begin
         unique case (bias)
            BI_STATIC: begin
               if (is_com || !sel)
                  level = pol ? LVL_GND : LVL_TOP;
               else
                  level = pol ? LVL_TOP : LVL_GND;
            end
            BI_HALF: begin
               if (is_com)
                  level = sel ? (pol ? LVL_GND : LVL_TOP) : LVL_MID1;
               else if (sel)
                  level = pol ? LVL_TOP : LVL_GND;
               else
                  level = pol ? LVL_GND : LVL_TOP;
            end
            BI_THIRD: begin
               if (is_com)
                  level = sel ? (pol ? LVL_GND : LVL_TOP)
                              : (pol ? LVL_MID1 : LVL_MID2);
               else if (sel)
                  level = pol ? LVL_TOP : LVL_GND;
               else
                  level = pol ? LVL_MID2 : LVL_MID1;
            end
            BI_QUARTER: begin
               if (is_com)
                  level = sel ? (pol ? LVL_TOP : LVL_GND)
                              : (pol ? LVL_MID3 : LVL_MID1);
               else if (sel)
                  level = pol ? LVL_GND : LVL_TOP;
               else
                  level = pol ? LVL_MID2 : LVL_MID1;
            end
         endcase
      end
   end

endmodule // lsd_level_enc

// File: hdl/lsd_dmem.sv
// Display data memory, one byte per segment line
`timescale 1ns/10ps
module lsd_dmem
   import lsd_pkg::*;
#(
   parameter int DEPTH = SEGS_LARGE
)
(
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               we,
   input  wire logic [4:0]         widx,
   input  wire logic [7:0]         wdata,
   input  wire logic [4:0]         ridx,
   output logic      [7:0]         rdata,
   output logic      [DEPTH*8-1:0] all_bytes
);

   localparam logic [4:0] NIB_LAST = 5'(DMEM_NIB_LAST_IDX - DMEM_FIRST_IDX);

   logic [7:0] mem_ff [DEPTH];

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < DEPTH; i++)
            mem_ff[i] <= 8'h00;
      end else if (we) begin
         if (widx <= NIB_LAST)
            mem_ff[widx] <= {4'h0, wdata[3:0]};
         else
            mem_ff[widx] <= wdata;
      end
   end

   assign rdata = mem_ff[ridx];

   always_comb begin
      for (int i = 0; i < DEPTH; i++)
         all_bytes[i*8 +: 8] = mem_ff[i];
   end

endmodule // lsd_dmem

// File: hdl/lsd_top.sv
// LCD segment and common drive sequencer with AHB-Lite register access
//
// Notes on behaviour
// - Large part: 32 segments from 32 bytes
// - Small part: 24 segments from 24 bytes
// - Common k active selects bit k
// - Bit one selects, bit zero deselects
// - Key-scan period takes patterns, not memory
// - Low nibble first half, high second
// - Segments 16 to 23 follow pattern bits
// - Unused high bits per mode ignored
// - First four bytes upper nibble reads zero
// - Only select on both gives on-voltage
// - Static: commons top/ground, segments by phase
// - Half bias levels and phases
// - Third bias levels and phases
// - Quarter bias levels and phases
// - Key-scan commons held at deselect level
// - Key-scan segments drive supply or ground
// - Commons activated in turn by slices
// - One key-scan slice after each cycle
// - Static mode drives all commons alike
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
module lsd_top
   import lsd_pkg::*;
#(
   parameter int          NUM_SEGS    = SEGS_LARGE,
   parameter int unsigned HALF_CYCLES = LCD_HALF_CYCLES
)
(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic      [NUM_COMS*3-1:0] com_level,
   output logic      [NUM_SEGS*3-1:0] seg_level,
   output logic      [1:0]            keyscan_phase,
   output logic                       lcd_polarity
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic                  ap_wr_ff;
   logic [31:0]           ap_addr_ff;
   logic [31:0]           hrdata_ff;
   logic                  disp_on_ff;
   logic                  segment_keyscan_enable_ff;
   lsd_slice_e            slice_ff;
   lsd_bias_e             bias_ff;
   logic [7:0]            keyscan_pattern_reg_a_ff;
   logic [7:0]            keyscan_pattern_reg_b_ff;
   logic [31:0]           div_ff;
   logic                  tick;
   logic                  pol_ff;
   logic [1:0]            com_ff;
   lsd_phase_e            phase_ff;
   lsd_phase_e            nxt_phase;
   logic [1:0]            nxt_com;
   logic [1:0]            last_com;
   logic                  ap_take;
   logic                  dm_we;
   logic [7:0]            dm_rdata;
   logic [NUM_SEGS*8-1:0] dm_bytes;
   logic [NUM_COMS-1:0]   com_sel;
   logic [NUM_SEGS-1:0]   seg_sel;
   logic [NUM_SEGS-1:0]   seg_key;
   logic [NUM_SEGS-1:0]   seg_kbit;
   lsd_lvl_e              com_lvl [NUM_COMS];
   lsd_lvl_e              seg_lvl [NUM_SEGS];
   logic [NUM_COMS*3-1:0] com_level_ff;
   logic [NUM_SEGS*3-1:0] seg_level_ff;
   lsd_phase_e            phase_out_ff;
   logic                  pol_out_ff;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   function automatic logic dm_hit(input logic [31:0] a);
      dm_hit = (a[31:7] == DMEM_BASE_ADDR[31:7]) && (a[1:0] == 2'b00)
               && (32'(a[6:2]) < 32'(NUM_SEGS));
   endfunction

   function automatic logic [31:0] rd_mux(input logic [31:0] a, input logic [7:0] dm);
      rd_mux = 32'h0000_0000;
      if (dm_hit(a))
         rd_mux = {24'h000000, dm};
      else if (a == CTRL_ADDR) begin
         rd_mux[CTRL_ON_BIT]            = disp_on_ff;
         rd_mux[CTRL_KS_BIT]            = segment_keyscan_enable_ff;
         rd_mux[CTRL_SL_LSB +: 2]       = slice_ff;
         rd_mux[CTRL_BI_LSB +: 2]       = bias_ff;
      end else if (a == PAT_A_ADDR)
         rd_mux = {24'h000000, keyscan_pattern_reg_a_ff};
      else if (a == PAT_B_ADDR)
         rd_mux = {24'h000000, keyscan_pattern_reg_b_ff};
      else if (a == STAT_ADDR) begin
         rd_mux[STAT_PH_LSB +: 2]       = phase_ff;
         rd_mux[STAT_COM_LSB +: 2]      = com_ff;
         rd_mux[STAT_POL_BIT]           = pol_ff;
      end
   endfunction

   // ---------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ---------------------------------------------------------------
   assign ap_take   = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_ff   <= 1'b0;
         ap_addr_ff <= 32'h0000_0000;
      end else if (hready) begin
         ap_wr_ff   <= ap_take && hwrite;
         ap_addr_ff <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata_ff <= 32'h0000_0000;
      else if (ap_take && !hwrite)
         hrdata_ff <= rd_mux(haddr, dm_rdata);
   end

   // Control and pattern registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         disp_on_ff                <= 1'b0;
         segment_keyscan_enable_ff <= 1'b0;
         slice_ff                  <= SL_STATIC;
         bias_ff                   <= BI_STATIC;
      end else if (ap_wr_ff && ap_addr_ff == CTRL_ADDR) begin
         disp_on_ff                <= hwdata[CTRL_ON_BIT];
         segment_keyscan_enable_ff <= hwdata[CTRL_KS_BIT];
         slice_ff                  <= lsd_slice_e'(hwdata[CTRL_SL_LSB +: 2]);
         bias_ff                   <= lsd_bias_e'(hwdata[CTRL_BI_LSB +: 2]);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         keyscan_pattern_reg_a_ff <= PAT_RESET;
         keyscan_pattern_reg_b_ff <= PAT_RESET;
      end else if (ap_wr_ff) begin
         if (ap_addr_ff == PAT_A_ADDR)
            keyscan_pattern_reg_a_ff <= hwdata[7:0];
         if (ap_addr_ff == PAT_B_ADDR)
            keyscan_pattern_reg_b_ff <= hwdata[7:0];
      end
   end

   assign dm_we = ap_wr_ff && dm_hit(ap_addr_ff);

   lsd_dmem #(
      .DEPTH     (NUM_SEGS)
   ) u_dmem (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .we        (dm_we),
      .widx      (ap_addr_ff[6:2]),
      .wdata     (hwdata[7:0]),
      .ridx      (haddr[6:2]),
      .rdata     (dm_rdata),
      .all_bytes (dm_bytes)
   );

   // ---------------------------------------------------------------
   // LCD clock divider and polarity
   // ---------------------------------------------------------------
   assign tick = (div_ff == 32'(HALF_CYCLES - 1));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         div_ff <= 32'h0000_0000;
      else if (!disp_on_ff || tick)
         div_ff <= 32'h0000_0000;
      else
         div_ff <= div_ff + 32'h0000_0001;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         pol_ff <= 1'b0;
      else if (!disp_on_ff)
         pol_ff <= 1'b0;
      else if (tick)
         pol_ff <= !pol_ff;
   end

   // ---------------------------------------------------------------
   // Slice sequencer
   // ---------------------------------------------------------------
   always_comb begin
      unique case (slice_ff)
         SL_STATIC: last_com = 2'h0;
         SL_TWO:    last_com = 2'h1;
         SL_THREE:  last_com = 2'h2;
         SL_FOUR:   last_com = 2'h3;
      endcase
   end

   always_comb begin
      nxt_phase = phase_ff;
      nxt_com   = com_ff;
      unique case (phase_ff)
         PH_DISP: begin
            if (com_ff >= last_com) begin
               nxt_com = 2'h0;
               if (segment_keyscan_enable_ff)
                  nxt_phase = PH_KEY_LO;
            end else begin
               nxt_com = com_ff + 2'h1;
            end
         end
         PH_KEY_LO: nxt_phase = PH_KEY_HI;
         PH_KEY_HI: nxt_phase = PH_DISP;
         default:   nxt_phase = PH_DISP;
      endcase
   end

   // A slice is one full LCD clock period; key halves are half periods
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_ff <= PH_DISP;
         com_ff   <= 2'h0;
      end else if (!disp_on_ff) begin
         phase_ff <= PH_DISP;
         com_ff   <= 2'h0;
      end else if (tick) begin
         if (phase_ff != PH_DISP)
            phase_ff <= nxt_phase;
         else if (pol_ff) begin
            phase_ff <= nxt_phase;
            com_ff   <= nxt_com;
         end
      end
   end

   // ---------------------------------------------------------------
   // Select decisions
   // ---------------------------------------------------------------
   always_comb begin
      for (int c = 0; c < NUM_COMS; c++)
         com_sel[c] = (phase_ff == PH_DISP)
                      && ((slice_ff == SL_STATIC) || (2'(c) == com_ff));
   end

   always_comb begin
      for (int s = 0; s < NUM_SEGS; s++) begin
         seg_sel[s]  = (phase_ff == PH_DISP) && dm_bytes[s*8 + int'(com_ff)];
         seg_key[s]  = (phase_ff != PH_DISP) && (s >= KEY_SEG_FIRST)
                       && (s < KEY_SEG_FIRST + KEY_SEG_NUM);
         seg_kbit[s] = 1'b0;
         if (seg_key[s]) begin
            if (s < KEY_SEG_FIRST + NIB_SEG_NUM)
               seg_kbit[s] = keyscan_pattern_reg_a_ff[(s - KEY_SEG_FIRST)
                              + ((phase_ff == PH_KEY_HI) ? NIB_SEG_NUM : 0)];
            else
               seg_kbit[s] = keyscan_pattern_reg_b_ff[(s - KEY_SEG_FIRST - NIB_SEG_NUM)
                              + ((phase_ff == PH_KEY_HI) ? NIB_SEG_NUM : 0)];
         end
      end
   end

   // ---------------------------------------------------------------
   // Level encoders
   // ---------------------------------------------------------------
   for (genvar c = 0; c < NUM_COMS; c++) begin : g_com
      lsd_level_enc u_enc (
         .is_com (1'b1),
         .sel    (com_sel[c]),
         .pol    (pol_ff),
         .key    (1'b0),
         .kbit   (1'b0),
         .bias   (bias_ff),
         .level  (com_lvl[c])
      );
   end

   for (genvar s = 0; s < NUM_SEGS; s++) begin : g_seg
      lsd_level_enc u_enc (
         .is_com (1'b0),
         .sel    (seg_sel[s]),
         .pol    (pol_ff),
         .key    (seg_key[s]),
         .kbit   (seg_kbit[s]),
         .bias   (bias_ff),
         .level  (seg_lvl[s])
      );
   end

   // ---------------------------------------------------------------
   // Registered outputs, ground while display is off
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         com_level_ff <= '0;
         seg_level_ff <= '0;
         phase_out_ff <= PH_DISP;
         pol_out_ff   <= 1'b0;
      end else begin
         // Phase and polarity ride in step with the level pins
         phase_out_ff <= phase_ff;
         pol_out_ff   <= pol_ff;
         for (int c = 0; c < NUM_COMS; c++)
            com_level_ff[c*3 +: 3] <= disp_on_ff ? com_lvl[c] : LVL_GND;
         for (int s = 0; s < NUM_SEGS; s++)
            seg_level_ff[s*3 +: 3] <= disp_on_ff ? seg_lvl[s] : LVL_GND;
      end
   end

   assign com_level     = com_level_ff;
   assign seg_level     = seg_level_ff;
   assign keyscan_phase = phase_out_ff;
   assign lcd_polarity  = pol_out_ff;

endmodule // lsd_top

// File: tb/lsd_monitor.sv
// Checker for the drive level outputs of the LCD drive block
`timescale 1ns/10ps
module lsd_monitor
   import lsd_pkg::*;
#(
   parameter int          NUM_SEGS    = SEGS_LARGE,
   parameter int unsigned HALF_CYCLES = LCD_HALF_CYCLES
)
(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic [NUM_COMS*3-1:0] com_level,
   input  wire logic [NUM_SEGS*3-1:0] seg_level,
   input  wire logic [1:0]            keyscan_phase,
   input  wire logic                  lcd_polarity
);
   int unsigned klo_cnt_ff;
   logic [3:0]  com_ext;
   logic [3:0]  com_mid;
   logic [7:0]  key_rail;
   logic        seg_vdd;

   always_comb begin
      seg_vdd = 1'b0;
      for (int c = 0; c < NUM_COMS; c++) begin
         com_ext[c] = com_level[3*c+:3] inside {LVL_GND, LVL_TOP};
         com_mid[c] = com_level[3*c+:3] inside {LVL_MID1, LVL_MID2, LVL_MID3};
      end
      for (int k = 0; k < KEY_SEG_NUM; k++) begin
         key_rail[k] = seg_level[3*(KEY_SEG_FIRST+k)+:3] inside {LVL_GND, LVL_VDD};
      end
      for (int s = 0; s < NUM_SEGS; s++) begin
         seg_vdd = seg_vdd | (seg_level[3*s+:3] == LVL_VDD);
      end
   end

   // Length of the first key-scan half
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         klo_cnt_ff <= 0;
      end else begin
         klo_cnt_ff <= (keyscan_phase == PH_KEY_LO) ? klo_cnt_ff + 1 : 0;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_key_com_desel: assert property (keyscan_phase != PH_DISP |-> com_mid == 4'hF)
      else $error("common not at deselect level in key-scan");
   a_key_seg_rail: assert property (keyscan_phase != PH_DISP |-> key_rail == 8'hFF)
      else $error("key segment not at a logic rail");
   a_disp_no_supply: assert property (keyscan_phase == PH_DISP |-> !seg_vdd)
      else $error("supply level on a segment in display period");
   a_lo_then_hi: assert property ($past(keyscan_phase) == PH_KEY_LO &&
      keyscan_phase != PH_KEY_LO |-> keyscan_phase == PH_KEY_HI)
      else $error("first key half not followed by second half");
   a_hi_then_disp: assert property ($past(keyscan_phase) == PH_KEY_HI &&
      keyscan_phase != PH_KEY_HI |-> keyscan_phase == PH_DISP)
      else $error("second key half not followed by display");
   a_lo_half_len: assert property ($past(keyscan_phase) == PH_KEY_LO &&
      keyscan_phase == PH_KEY_HI |-> klo_cnt_ff == HALF_CYCLES)
      else $error("first key half has wrong length");
   a_lo_pol_low: assert property (keyscan_phase == PH_KEY_LO |-> !lcd_polarity)
      else $error("polarity high in first key half");
   a_hi_pol_high: assert property (keyscan_phase == PH_KEY_HI |-> lcd_polarity)
      else $error("polarity low in second key half");
   a_one_com_sel: assert property (keyscan_phase == PH_DISP && (|com_mid)
      |-> $countones(com_ext) == 1)
      else $error("not exactly one common selected");
endmodule // lsd_monitor

bind lsd_top lsd_monitor #(.NUM_SEGS(NUM_SEGS), .HALF_CYCLES(HALF_CYCLES)) i_lsd_monitor (
   .hclk(hclk),
   .hresetn(hresetn),
   .com_level(com_level),
   .seg_level(seg_level),
   .keyscan_phase(keyscan_phase),
   .lcd_polarity(lcd_polarity)
);

// File: tb/lsd_glass_model.sv
// Glass panel model: flags pixels that see the full on-voltage
`timescale 1ns/10ps
module lsd_glass_model
   import lsd_pkg::*;
#(
   parameter int NUM_SEGS = SEGS_LARGE
)
(
   input  wire logic [NUM_COMS*3-1:0]        com_level,
   input  wire logic [NUM_SEGS*3-1:0]        seg_level,
   output logic      [NUM_COMS*NUM_SEGS-1:0] pixel_on
);
   logic [2:0] cl;
   logic [2:0] sl;

   always_comb begin
      cl = '0;
      sl = '0;
      for (int c = 0; c < NUM_COMS; c++) begin
         for (int s = 0; s < NUM_SEGS; s++) begin
            cl = com_level[3*c+:3];
            sl = seg_level[3*s+:3];
            pixel_on[c*NUM_SEGS+s] = (cl inside {LVL_GND, LVL_TOP}) &&
               (sl inside {LVL_GND, LVL_TOP}) && (cl != sl);
         end
      end
   end
endmodule // lsd_glass_model

// File: tb/lsd_top_bench.sv
// Self-checking bench for the LCD drive block
`timescale 1ns/10ps
`define CHK(o, e) begin num_checks++; if ((o) !== (e)) begin errors++; \
   $display("MISMATCH %0t got %h exp %h", $time, o, e); end end
module lsd_top_bench
   import lsd_pkg::*;
;
   localparam int          NS = 32;
   localparam int unsigned HC = 4;
   logic               hclk;
   logic               hresetn, hsel, hwrite, rd_ack;
   logic [31:0]        haddr, hwdata, hrdata, obs, e1, e2;
   logic [1:0]         htrans, keyscan_phase;
   logic [2:0]         hsize;
   logic               hreadyout, hresp, lcd_polarity;
   logic [11:0]        com_level;
   logic [NS*3-1:0]    seg_level;
   logic [4*NS-1:0]    pixel_on;
   logic [7:0]         mem [NS];
   logic [7:0]         pa, pb;
   logic [31:0]        expq [$];
   int                 errors, num_checks, pk, pc;
   event               ev_look;

   lsd_top #(.NUM_SEGS(NS), .HALF_CYCLES(HC)) i_lsd_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .com_level(com_level),
      .seg_level(seg_level), .keyscan_phase(keyscan_phase), .lcd_polarity(lcd_polarity));
   lsd_glass_model #(.NUM_SEGS(NS)) i_lsd_glass_model (
      .com_level(com_level), .seg_level(seg_level), .pixel_on(pixel_on));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // ------------------------------------------------------------
   // Watchers: take the oldest note when a result appears
   // ------------------------------------------------------------
   always @(posedge hclk) begin
      if (rd_ack && hreadyout) begin
         e1 = expq.pop_front();
         `CHK(hrdata, e1)
      end
   end
   initial forever begin
      @(ev_look);
      case (pk)
         0: obs = pixel_on[pc*NS+:NS];
         1: obs = {8'h00, seg_level[3*KEY_SEG_FIRST+:24]};
         default: obs = {20'h00000, com_level};
      endcase
      e2 = expq.pop_front();
      `CHK(obs, e2)
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      rd_ack <= !wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_ack <= 1'b0;
      hsel <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   task automatic look(input int k, input int i, input logic [31:0] e);
      @(negedge hclk);
      pk = k;
      pc = i;
      expq.push_back(e);
      ->ev_look;
   endtask
   task automatic wt(input int k, input int c);
      logic hit;
      for (int n = 0; n < 400; n++) begin
         @(negedge hclk);
         case (k)
            0: hit = keyscan_phase == PH_DISP && com_level[3*c+:3] inside {LVL_GND, LVL_TOP}
               && com_level[3*((c+1)%4)+:3] inside {LVL_MID1, LVL_MID2, LVL_MID3}
               && lcd_polarity === 1'b0;
            1: hit = keyscan_phase == 2'(c);
            default: hit = lcd_polarity === 1'b1;
         endcase
         if (hit) return;
      end
      errors++;
      $display("MISMATCH %0t wait expired", $time);
   endtask
   function automatic logic [31:0] row(input int c);
      row = '0;
      for (int s = 0; s < NS; s++) row[s] = mem[s][c];
   endfunction
   function automatic logic [31:0] keyexp(input int h);
      keyexp = '0;
      for (int k = 0; k < NIB_SEG_NUM; k++) begin
         keyexp[3*k+:3] = pa[4*h+k] ? LVL_VDD : LVL_GND;
         keyexp[3*(k+4)+:3] = pb[4*h+k] ? LVL_VDD : LVL_GND;
      end
   endfunction
   function automatic logic [31:0] comkey(input int m, input int h);
      lsd_lvl_e l;
      l = (m == 1) ? LVL_MID1 : (m == 2) ? (h ? LVL_MID1 : LVL_MID2) : (h ? LVL_MID3 : LVL_MID1);
      comkey = {20'h00000, {4{l}}};
   endfunction
   task automatic report_and_stop();
      $display("TB: checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      errors++;
      $display("MISMATCH %0t run too long", $time);
      report_and_stop();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {hresetn, hsel, hwrite, rd_ack, htrans} = '0;
      {haddr, hwdata} = '0;
      hsize = 3'h2;
      errors = 0;
      num_checks = 0;
      void'($urandom(32'h3365d505));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rd(CTRL_ADDR, 32'h0000_0000);
      rd(PAT_A_ADDR, {24'h000000, PAT_RESET});
      rd(PAT_B_ADDR, {24'h000000, PAT_RESET});
      rd(32'h0000_0100, 32'h0000_0000);
      for (int s = 0; s < NS; s++) begin
         mem[s] = 8'($urandom);
         bus(1'b1, DMEM_BASE_ADDR + 32'(4*s), {24'h000000, mem[s]});
         if (s < 4) mem[s][7:4] = 4'h0;
      end
      for (int s = 0; s < NS; s++) rd(DMEM_BASE_ADDR + 32'(4*s), {24'h000000, mem[s]});
      pa = 8'($urandom);
      pb = 8'($urandom);
      bus(1'b1, PAT_A_ADDR, {24'h000000, pa});
      bus(1'b1, PAT_B_ADDR, {24'h000000, pb});
      rd(PAT_B_ADDR, {24'h000000, pb});
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, CTRL_ADDR, {22'h0, 2'(m), 2'b00, 2'(m), 2'b00, m != 0, 1'b1});
         if (m == 0) begin
            wt(2, 0);
            for (int c = 0; c < NUM_COMS; c++) look(0, c, row(0));
         end else begin
            for (int c = 0; c <= m; c++) begin
               wt(0, c);
               look(0, c, row(c));
            end
            wt(1, 1);
            look(1, 0, keyexp(0));
            look(2, 0, comkey(m, 0));
            wt(1, 3);
            look(1, 0, keyexp(1));
            look(2, 0, comkey(m, 1));
         end
      end
      repeat (4) @(posedge hclk);
      report_and_stop();
   end
endmodule // lsd_top_bench
